// ### core/ewp_defines.svh
// Timing counts and sequence codes for the EEPROM write controller
`ifndef EWP_DEFINES_SVH
`define EWP_DEFINES_SVH

// ==========================================================
// Clock and timing
// ==========================================================
`define EWP_CLK_NS        40
// Write strobe low width, ns (least)
`define EWP_T_WP_NS       100
`define EWP_WP_CYC        ((`EWP_T_WP_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS)
// Data setup before strobe rise, ns (least)
`define EWP_T_DS_NS       50
// Byte load cycle, us (longest)
`define EWP_T_BLC_US      30
`define EWP_BLC_CYC       ((`EWP_T_BLC_US * 1000) / `EWP_CLK_NS)
// Strobe high window that starts the internal write, us
`define EWP_T_BL_US       100
`define EWP_BL_CYC        ((`EWP_T_BL_US * 1000 + `EWP_CLK_NS - 1) / `EWP_CLK_NS)
// Hold-off reset kept high after the last byte, ms
`define EWP_T_WC_MS       10
`define EWP_WC_CYC        ((`EWP_T_WC_MS * 1000000 + `EWP_CLK_NS - 1) / `EWP_CLK_NS)

// ==========================================================
// Sequence codes
// ==========================================================
`define EWP_ADR_A         13'h1555
`define EWP_ADR_B         13'h0aaa
`define EWP_DAT_AA        8'haa
`define EWP_DAT_55        8'h55
`define EWP_DAT_80        8'h80
`define EWP_DAT_A0        8'ha0
`define EWP_DAT_20        8'h20

`endif

// ### core/ewp_host.sv
// Host-side controller that writes a parallel EEPROM and keeps it write-protected
//
// Summary of operation
// - Idle pins: select high, output-enable low, strobe high
// - Hold-off reset follows host reset directly
// - Hold-off stays high 10 ms after last byte
// - Protected mode: code precedes every data write
// - Six-byte sequence cancels protection
// - Address at strobe fall, data at rise
// - Bytes within 30 us; 100 us high commits
`timescale 1ns/100ps
`include "ewp_defines.svh"

module ewp_host (
   input  wire logic                sys_clk,        // 25 MHz clock
   input  wire logic                rst,            // Synchronous reset, active high
   input  wire logic                clk_en,         // Freezes all state while low
   input  wire logic                req_valid,      // Request strobe
   input  wire ewp_pkg::ewp_cmd_type req_cmd,       // Kind of request
   input  wire logic [12:0]         req_addr,       // Byte address for plain writes
   input  wire logic [7:0]          req_data,       // Byte data for plain writes
   output logic                     req_ready,      // Controller can take a request
   output logic                     busy,           // Sequence or internal write running
   output logic                     write_lock_mode,// Host view of protection state
   input  wire logic                abort_req,      // Drops hold-off, only while the controller is idle
   output logic [12:0]              mem_addr,       // Address pins
   output logic [7:0]               mem_dq_out,     // Data pins out
   output logic                     mem_dq_oe_n,    // Data pin enable, low drives
   output logic                     mem_cs_n,       // Chip select
   output logic                     mem_oe_n,       // Output enable
   output logic                     mem_we_n,       // Write strobe
   output logic                     hold_off_n      // Hold-off reset pin
);
   // ==========================================================
   // Declarations
   // ==========================================================
   ewp_pkg::ewp_state_type state, next_state;   // Sequencer state
   ewp_pkg::ewp_cmd_type   cmd;                 // Command in progress
   logic [2:0]   idx;                           // Byte within sequence
   logic [2:0]   last_idx;                      // Index of final byte
   logic [12:0]  usr_addr;                      // Latched user address
   logic [7:0]   usr_data;                      // Latched user data
   logic [18:0]  cnt;                           // Cycle counter, holds up to 10 ms
   logic         lock_seen;                     // Protection believed on
   logic         abort_s1, abort_s2;            // Abort input synchroniser
   logic [12:0]  seq_addr;                      // Address of current byte
   logic [7:0]   seq_data;                      // Data of current byte
   logic         cnt_done;                      // Counter reached its target
   logic [18:0]  cnt_goal;                      // Target for the current state

   // ==========================================================
   // Byte table
   // ==========================================================
   // Code and cancel sequence bytes
   wire          is_unlock = (cmd == ewp_pkg::EWP_CMD_UNLOCK);
   wire          use_code  = lock_seen || (cmd == ewp_pkg::EWP_CMD_LOCK);
   wire          tbl_b     = (idx == 3'd1) || (idx == 3'd4);
   wire [7:0]    tbl_unl   = (idx == 3'd2) ? `EWP_DAT_80 :
                             (idx == 3'd5) ? `EWP_DAT_20 :
                             ((idx == 3'd1) || (idx == 3'd4)) ? `EWP_DAT_55 : `EWP_DAT_AA;
   wire [7:0]    tbl_code  = (idx == 3'd1) ? `EWP_DAT_55 :
                             (idx == 3'd2) ? `EWP_DAT_A0 : `EWP_DAT_AA;
   wire          user_byte = !is_unlock && (idx == last_idx) && (cmd == ewp_pkg::EWP_CMD_WRITE);
   assign seq_addr = user_byte ? usr_addr : (tbl_b ? `EWP_ADR_B : `EWP_ADR_A);
   assign seq_data = user_byte ? usr_data : (is_unlock ? tbl_unl : tbl_code);
   assign cnt_done = (cnt >= cnt_goal);
   assign cnt_goal = (state == ewp_pkg::EWP_STROBE) ? 19'(`EWP_WP_CYC) :
                     (state == ewp_pkg::EWP_WAIT) ? 19'(`EWP_BL_CYC) :
                     (state == ewp_pkg::EWP_HOLD) ? 19'(`EWP_WC_CYC) : 19'd1;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      next_state = state;
      case (state)
         ewp_pkg::EWP_IDLE: begin
            if (req_valid) begin
               next_state = ewp_pkg::EWP_SETUP;
            end
         end
         // Address and data settle one cycle before the strobe falls
         // Two cycles: pins load in the first, strobe falls after the second
         ewp_pkg::EWP_SETUP: begin
            if (cnt_done) begin
               next_state = ewp_pkg::EWP_STROBE;
            end
         end
         ewp_pkg::EWP_STROBE: begin
            if (cnt_done) begin
               next_state = (idx == last_idx) ? ewp_pkg::EWP_WAIT : ewp_pkg::EWP_GAP;
            end
         end
         // Next byte starts well inside 30 us
         ewp_pkg::EWP_GAP:    next_state = ewp_pkg::EWP_SETUP;
         ewp_pkg::EWP_WAIT: begin
            if (cnt_done) begin
               next_state = ewp_pkg::EWP_HOLD;
            end
         end
         ewp_pkg::EWP_HOLD: begin
            if (cnt_done) begin
               next_state = ewp_pkg::EWP_IDLE;
            end
         end
         default: next_state = ewp_pkg::EWP_IDLE;
      endcase
   end

   // ==========================================================
   // Sequencer registers
   // ==========================================================
   // Abort comes from outside logic, so it passes two flip-flops
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         abort_s1 <= 1'b0;
         abort_s2 <= 1'b0;
      end else if (clk_en) begin
         abort_s1 <= abort_req;
         abort_s2 <= abort_s1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= ewp_pkg::EWP_IDLE;
         cnt   <= 19'd0;
      end else if (clk_en) begin
         state <= next_state;
         cnt   <= (next_state != state) ? 19'd0 : cnt + 19'd1;
      end
   end

   // Request capture; index advances once per byte
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd      <= ewp_pkg::EWP_CMD_WRITE;
         usr_addr <= 13'h0000;
         usr_data <= 8'h00;
         idx      <= 3'd0;
         last_idx <= 3'd0;
      end else if (clk_en) begin
         if (state == ewp_pkg::EWP_IDLE && req_valid) begin
            cmd      <= req_cmd;
            usr_addr <= req_addr;
            usr_data <= req_data;
            idx      <= 3'd0;
            // Lock is the bare three-byte code
            last_idx <= (req_cmd == ewp_pkg::EWP_CMD_UNLOCK) ? 3'd5 :
                        (req_cmd == ewp_pkg::EWP_CMD_LOCK) ? 3'd2 :
                        (lock_seen ? 3'd3 : 3'd0);
         end else if (state == ewp_pkg::EWP_GAP) begin
            idx <= idx + 3'd1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lock_seen <= 1'b0;
      end else if (clk_en && state == ewp_pkg::EWP_WAIT && cnt_done) begin
         lock_seen <= use_code && !is_unlock;
      end
   end

   // ==========================================================
   // Pin drive
   // ==========================================================
   // Address before fall, data stable to rise
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_addr   <= 13'h0000;
         mem_dq_out <= 8'h00;
      end else if (clk_en && state == ewp_pkg::EWP_SETUP && !cnt_done) begin
         mem_addr   <= seq_addr;
         mem_dq_out <= seq_data;
      end
   end

   wire in_byte = (state == ewp_pkg::EWP_STROBE);
   // Data stays driven one cycle past the last strobe rise, so the rising
   // edge never meets a released bus
   wire in_tail = (state == ewp_pkg::EWP_WAIT) && (cnt == 19'd0);
   wire driving = (state == ewp_pkg::EWP_SETUP) || in_byte || (state == ewp_pkg::EWP_GAP)
                  || in_tail;
   // Idle keeps select high and output-enable low
   assign mem_cs_n    = !in_byte;
   assign mem_we_n    = !in_byte;
   // Output enable must be high while writing, or the device refuses to program
   assign mem_oe_n    = driving;
   assign mem_dq_oe_n = !driving;
   // Abort is ignored while hold-off guard runs
   assign hold_off_n  = !rst && !(abort_s2 && state == ewp_pkg::EWP_IDLE);
   assign req_ready   = (state == ewp_pkg::EWP_IDLE) && !rst;
   assign busy        = (state != ewp_pkg::EWP_IDLE);
   assign write_lock_mode = lock_seen;

   // ==========================================================
   // Checks
   // ==========================================================
   AST_IDLE_SAFE: assert property (@(posedge sys_clk) disable iff (rst)
      (state == ewp_pkg::EWP_IDLE) |-> (mem_cs_n && mem_we_n))
      else $error("Device not held unprogrammable while idle");
   AST_HOLD_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
      (state == ewp_pkg::EWP_HOLD) |-> hold_off_n)
      else $error("Hold-off dropped during internal write");
   AST_STROBE_W: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
      $fell(mem_we_n) |-> !mem_we_n [*3])
      else $error("Write strobe pulse too short");
   AST_ADDR_STABLE: assert property (@(posedge sys_clk) disable iff (rst)
      (!mem_we_n && $past(!mem_we_n)) |-> $stable(mem_addr) && $stable(mem_dq_out))
      else $error("Address or data moved inside strobe");
   AST_GAP_SHORT: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
      (state == ewp_pkg::EWP_GAP) |-> ##3 !mem_we_n)
      else $error("Next byte late inside page load");
   AST_UNLOCK_CLR: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && state == ewp_pkg::EWP_WAIT && cnt_done && is_unlock) |=> !write_lock_mode)
      else $error("Cancel did not clear protection");
   AST_LOCK_SET: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && state == ewp_pkg::EWP_WAIT && cnt_done && cmd == ewp_pkg::EWP_CMD_LOCK)
      |=> write_lock_mode)
      else $error("Code did not set protection");
   AST_CODE_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
      (state == ewp_pkg::EWP_SETUP && lock_seen && !is_unlock && idx == 3'd0)
      |-> (seq_addr == `EWP_ADR_A && seq_data == `EWP_DAT_AA))
      else $error("Protected write not led by code");
endmodule : ewp_host

// ### core/ewp_pkg.sv
// Types shared by the EEPROM write controller
package ewp_pkg;
   // ==========================================================
   // Command and state types
   // ==========================================================
   typedef enum logic [1:0] {
      EWP_CMD_WRITE  = 2'b00,   // Plain data byte
      EWP_CMD_LOCK   = 2'b01,   // Code only: enable protection
      EWP_CMD_UNLOCK = 2'b10    // Six-byte cancelling sequence
   } ewp_cmd_type;

   typedef enum logic [2:0] {
      EWP_IDLE   = 3'b000,
      EWP_SETUP  = 3'b001,
      EWP_STROBE = 3'b010,
      EWP_GAP    = 3'b011,
      EWP_WAIT   = 3'b100,
      EWP_HOLD   = 3'b101
   } ewp_state_type;
endpackage : ewp_pkg

// ### tb/ewp_eeprom_model.sv
// Behavioural model of the protected parallel EEPROM driven by the controller
`timescale 1ns/100ps
`include "ewp_defines.svh"
module ewp_eeprom_model (
   input wire logic [12:0] mem_addr,
   input wire logic [7:0]  mem_dq_out,
   input wire logic        mem_dq_oe_n,
   input wire logic        mem_cs_n,
   input wire logic        mem_oe_n,
   input wire logic        mem_we_n,
   input wire logic        hold_off_n
);
   // ==========================================================
   // Array, protection state and byte logs
   // ==========================================================
   logic [7:0]  mem [0:8191];      // Cells, erased to ff
   logic [12:0] log_a[$], ld_a[$], pa[$]; // All bytes, page load, pending write
   logic [7:0]  log_d[$], ld_d[$], pd[$];
   logic [12:0] lat_a;             // Address taken at strobe start
   logic        protect = 1'b0;
   logic        wip = 1'b0;        // Internal write running
   int          blc_err = 0;       // Late byte loads
   int          pend_n = 0;        // Bytes of the last committed write
   realtime     t_fall = 0, t_rise = 0, t_done = 0;
   // strobe counts only with select low, output enable high, hold-off high
   wire logic   strobe = !mem_cs_n && !mem_we_n && mem_oe_n && hold_off_n;
   initial foreach (mem[i]) mem[i] = 8'hff;
   // address at strobe start; spacing from the previous start
   always @(posedge strobe) begin
      if (ld_a.size() > 0 && $realtime - t_fall > `EWP_T_BLC_US * 1000.0) blc_err++;
      t_fall = $realtime;
      lat_a = mem_addr;
   end
   // data at strobe end; an undriven bus reads back inverted
   always @(negedge strobe) begin
      ld_a.push_back(lat_a);
      ld_d.push_back(mem_dq_oe_n ? ~mem_dq_out : mem_dq_out);
      log_a.push_back(lat_a);
      log_d.push_back(mem_dq_oe_n ? ~mem_dq_out : mem_dq_out);
      t_rise = $realtime;
   end
   // three-byte code starting at load position i
   function automatic bit code_at(int i, logic [7:0] d3);
      return ld_a.size() >= i + 3 && ld_a[i] === `EWP_ADR_A && ld_d[i] === `EWP_DAT_AA
         && ld_a[i+1] === `EWP_ADR_B && ld_d[i+1] === `EWP_DAT_55
         && ld_a[i+2] === `EWP_ADR_A && ld_d[i+2] === d3;
   endfunction
   // decode the closed load and start the internal write
   task automatic commit();
      int s;
      s = 0;
      pa = {};
      pd = {};
      if (code_at(0, `EWP_DAT_80) && code_at(3, `EWP_DAT_20)) begin
         protect = 1'b0;
         s = 99;
      end else if (code_at(0, `EWP_DAT_A0)) begin
         protect = 1'b1;
         s = 3;
      end else if (protect) begin
         s = 99;
      end
      for (int i = s; i < ld_a.size(); i++) begin
         pa.push_back(ld_a[i]);
         pd.push_back(ld_d[i]);
      end
      ld_a = {};
      ld_d = {};
      pend_n = pa.size();
      wip = pa.size() > 0;
      t_done = $realtime + `EWP_T_WC_MS * 1.0e6;
   endtask
   // strobe high for the load window commits; polled each microsecond
   always begin
      #1000;
      if (!wip && ld_a.size() > 0 && !strobe
          && $realtime - t_rise >= `EWP_T_BL_US * 1000.0) commit();
      if (wip && $realtime >= t_done) begin
         foreach (pa[i]) mem[pa[i]] = pd[i];
         wip = 1'b0;
      end
   end
   // hold-off low aborts, leaving the targets wrong
   always @(negedge hold_off_n) begin
      if (wip) foreach (pa[i]) mem[pa[i]] = ~pd[i];
      wip = 1'b0;
      ld_a = {};
      ld_d = {};
   end
endmodule : ewp_eeprom_model

// ### tb/ewp_host_tb.sv
// Testbench of the EEPROM write controller against the device model
`timescale 1ns/100ps
`include "ewp_defines.svh"
module ewp_host_tb;
   // ==========================================================
   // Stimulus, observed pins and instances
   // ==========================================================
   logic                 sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
   logic                 req_valid = 1'b0, abort_req = 1'b0;
   ewp_pkg::ewp_cmd_type req_cmd = ewp_pkg::EWP_CMD_WRITE;
   logic [12:0]          req_addr = 13'h0000, mem_addr;
   logic [7:0]           req_data = 8'h00, mem_dq_out;
   logic                 req_ready, busy, write_lock_mode, mem_dq_oe_n;
   logic                 mem_cs_n, mem_oe_n, mem_we_n, hold_off_n;
   int                   error_cnt = 0, comparisons = 0, nlog = 0, n, bad;
   typedef struct {ewp_pkg::ewp_cmd_type c; logic [20:0] u; int nb; logic lk, pr;
                   logic [12:0] pa; logic [7:0] pm;} ewp_row_type;
   // Rows: request, bytes, host lock view, device lock and a probed cell after reset
   ewp_row_type rows [3] = '{'{ewp_pkg::EWP_CMD_WRITE, 21'h01235a, 1, 0, 0, 13'h0123, 8'ha5},
      '{ewp_pkg::EWP_CMD_LOCK, 21'h0, 3, 1, 1, 13'h0123, 8'ha5},
      '{ewp_pkg::EWP_CMD_UNLOCK, 21'h0, 6, 0, 0, 13'h1555, 8'hff}};
   ewp_host u_ewp_host (.sys_clk, .rst, .clk_en, .req_valid, .req_cmd, .req_addr, .req_data,
      .req_ready, .busy, .write_lock_mode, .abort_req, .mem_addr, .mem_dq_out, .mem_dq_oe_n,
      .mem_cs_n, .mem_oe_n, .mem_we_n, .hold_off_n);
   ewp_eeprom_model u_ewp_eeprom_model (.mem_addr, .mem_dq_out, .mem_dq_oe_n, .mem_cs_n,
      .mem_oe_n, .mem_we_n, .hold_off_n);
   // Half period of 20 ns gives 25 MHz
   always #20 sys_clk = ~sys_clk;
   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Bounded wait step; inputs move 2 ns after the edge
   task automatic tick(inout int k, input int lim);
      @(posedge sys_clk);
      #2;
      k++;
      if (k > lim) begin
         error_cnt++;
         $display("[ERR] t=%0t wait bound %0d exhausted", $time, lim);
         finish_test();
      end
   endtask : tick
   task automatic finish_test();
      $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic do_reset();
      rst = 1'b1;
      repeat (5) @(posedge sys_clk);
      #2;
      check({mem_cs_n, mem_we_n, mem_oe_n, hold_off_n, req_ready, busy, write_lock_mode},
            7'h60);
      rst = 1'b0;
   endtask : do_reset
   // Expected address and data of byte i of a request
   function automatic logic [20:0] exp_byte(ewp_pkg::ewp_cmd_type c, logic [20:0] u,
                                            int nb, int i);
      if (c == ewp_pkg::EWP_CMD_WRITE && i == nb - 1) return u;
      case (i % 3)
         0: return {`EWP_ADR_A, `EWP_DAT_AA};
         1: return {`EWP_ADR_B, `EWP_DAT_55};
         default: return {`EWP_ADR_A, (i == 5) ? `EWP_DAT_20 :
            (c == ewp_pkg::EWP_CMD_UNLOCK) ? `EWP_DAT_80 : `EWP_DAT_A0};
      endcase
   endfunction : exp_byte
   task automatic run_op(input ewp_pkg::ewp_cmd_type c, input logic [20:0] u, input int nb);
      int k;
      k = 0;
      while (req_ready !== 1'b1) tick(k, 100);
      req_cmd = c;
      req_addr = u[20:8];
      req_data = u[7:0];
      req_valid = 1'b1;
      tick(k, 100);
      req_valid = 1'b0;
      check(busy, 1'b1);
      k = 0;
      while (u_ewp_eeprom_model.log_a.size() < nlog + nb) tick(k, 1000);
      for (int i = 0; i < nb; i++) begin
         check({u_ewp_eeprom_model.log_a[nlog+i], u_ewp_eeprom_model.log_d[nlog+i]},
               exp_byte(c, u, nb, i));
      end
      nlog += nb;
   endtask : run_op
   // The load window closes after 100 us of strobe high; no extra byte may follow
   // Host lock view only settles once that window has closed
   task automatic settle(input logic lk);
      repeat (`EWP_BL_CYC + 100) @(posedge sys_clk);
      #2;
      check(write_lock_mode, lk);
      check(u_ewp_eeprom_model.log_a.size(), nlog);
      check(u_ewp_eeprom_model.blc_err, 0);
   endtask : settle
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      do_reset();
      clk_en = 1'b0;
      req_valid = 1'b1;
      repeat (5) @(posedge sys_clk);
      #2;
      check({busy, mem_cs_n, mem_oe_n}, 3'h2);
      req_valid = 1'b0;
      clk_en = 1'b1;
      $display("test freeze done");
      abort_req = 1'b1;
      repeat (4) @(posedge sys_clk);
      #2;
      check(hold_off_n, 1'b0);
      abort_req = 1'b0;
      repeat (4) @(posedge sys_clk);
      #2;
      check(hold_off_n, 1'b1);
      $display("test abort pin done");
      foreach (rows[r]) begin
         run_op(rows[r].c, rows[r].u, rows[r].nb);
         settle(rows[r].lk);
         do_reset();
         check(u_ewp_eeprom_model.protect, rows[r].pr);
         check(u_ewp_eeprom_model.mem[rows[r].pa], rows[r].pm);
         $display("test row %0d done", r);
      end
      // Full lock, a refused request while busy, hold-off kept through the write
      // Abort is held up through the guard; hold-off must not drop while busy
      run_op(ewp_pkg::EWP_CMD_LOCK, 21'h0, 3);
      n = 0;
      bad = 0;
      req_valid = 1'b1;
      abort_req = 1'b1;
      tick(n, 300000);
      req_valid = 1'b0;
      while (busy === 1'b1) begin
         tick(n, 300000);
         bad += (busy === 1'b1 && hold_off_n !== 1'b1);
      end
      abort_req = 1'b0;
      repeat (3) @(posedge sys_clk);
      #2;
      check(n >= `EWP_WC_CYC, 1'b1);
      check(bad, 0);
      check(write_lock_mode, 1'b1);
      check(u_ewp_eeprom_model.protect, 1'b1);
      $display("test full lock done");
      run_op(ewp_pkg::EWP_CMD_WRITE, {13'h0040, 8'h3c}, 4);
      settle(1'b1);
      check(u_ewp_eeprom_model.pend_n, 1);
      do_reset();
      check(u_ewp_eeprom_model.mem[13'h0040], 8'hc3);
      $display("test protected write done");
      finish_test();
   end
endmodule : ewp_host_tb
